// *** sml_host.sv ***
`timescale 1ns/1ps
`default_nettype none
module sml_host (
  input wire logic clk, // Clock.
  input wire logic ready, // Bus ready.
  input wire logic [31:0] rdata, // Read data.
  output logic hsel, // Select.
  output logic [31:0] haddr, // Address.
  output logic [1:0] htrans, // Transfer type.
  output logic hwrite, // Write.
  output logic [2:0] hsize, // Size.
  output logic [31:0] hwdata, // Write data.
  output logic done, // Read data taken.
  output logic [31:0] val // Data taken.
);
  initial begin
    hsel = 1'b1;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
    done = 1'b0;
    val = 32'h0;
  end
  always @(posedge clk)
    if (done)
      done <= 1'b0;
  // Data is inverted after its phase so a stale value never looks valid.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge clk); while (ready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= w ? d : ~hwdata;
    do @(posedge clk); while (ready !== 1'b1);
    val <= rdata;
    done <= !w;
    hwdata <= ~hwdata;
  endtask : xfer
endmodule : sml_host
`default_nettype wire

// *** sml_limit_store.sv ***
`timescale 1ns/1ps
`default_nettype none
module sml_limit_store
  import sml_pkg::*;
(
  input wire logic clk, // Clock.
  input wire logic rst, // Asynchronous reset (power cycle).
  input wire logic ld, // Load a new limit.
  input wire logic [27:0] ld_val, // New limit.
  input wire logic ld_persist, // Keep across power-on reset.
  input wire logic [27:0] native_max, // Native capacity limit.
  output logic [27:0] limit, // Limit in force.
  output logic persist // Current limit is nonvolatile.
);
  logic [27:0] nv_r;
  logic nv_valid_r;
  logic [27:0] vol_r;
  logic vol_valid_r;
  logic booted_r;

  // The nonvolatile copy stands for a backing store and is not cleared by rst.
  always_ff @(posedge clk) begin
    if (ld && ld_persist) begin
      nv_r <= ld_val;
      nv_valid_r <= 1'b1;
    end else if (!booted_r && nv_valid_r !== 1'b1) begin
      nv_valid_r <= 1'b0;
    end
  end

  // The volatile copy is dropped at every reset.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      vol_r <= 28'h0000000;
      vol_valid_r <= 1'b0;
      booted_r <= 1'b0;
    end else begin
      booted_r <= 1'b1;
      if (ld) begin
        vol_r <= ld_val;
        vol_valid_r <= !ld_persist;
      end
    end
  end

  assign limit = vol_valid_r ? vol_r : (nv_valid_r === 1'b1 ? nv_r : native_max);
  assign persist = !vol_valid_r && nv_valid_r === 1'b1;
endmodule : sml_limit_store
`default_nettype wire

// *** sml_pkg.sv ***
package sml_pkg;
  // Register byte offsets on the register bus.
  localparam logic [7:0] OFF_CMD = 8'h00;
  localparam logic [7:0] OFF_FEAT = 8'h04;
  localparam logic [7:0] OFF_SECCNT = 8'h08;
  localparam logic [7:0] OFF_SECNUM = 8'h0c;
  localparam logic [7:0] OFF_CYLLO = 8'h10;
  localparam logic [7:0] OFF_CYLHI = 8'h14;
  localparam logic [7:0] OFF_DEVHEAD = 8'h18;
  localparam logic [7:0] OFF_DATA = 8'h1c;
  localparam logic [7:0] OFF_ERROR = 8'h20;
  localparam logic [7:0] OFF_STATUS = 8'h24;
  localparam logic [7:0] OFF_LIMIT = 8'h28;
  localparam logic [7:0] OFF_CTRL = 8'h2c;
  localparam logic [7:0] OFF_STATE = 8'h30;
  localparam logic [7:0] OFF_PWD = 8'h34;
  // Command codes.
  localparam logic [7:0] CMD_SET_LIMIT = 8'hf9;
  localparam logic [7:0] CMD_READ_NATIVE = 8'hf8;
  // Feature codes.
  localparam logic [7:0] FEAT_SET_PWD = 8'h01;
  localparam logic [7:0] FEAT_LOCK = 8'h02;
  localparam logic [7:0] FEAT_UNLOCK = 8'h03;
  localparam logic [7:0] FEAT_FREEZE = 8'h04;
  // Field positions.
  localparam int BIT_PERSIST = 0;
  localparam int BIT_LBA = 6;
  localparam int BIT_ABORT = 2;
  localparam int BIT_ERR = 0;
  localparam int BIT_XFER_REQ = 3;
  localparam int BIT_RDY = 6;
  localparam int BIT_BUSY = 7;
  localparam int BIT_FAULT = 5;
  localparam int BIT_OFFSET_MODE = 0;
  // Sector layout in 16-bit words.
  localparam int SECTOR_WORDS = 256;
  localparam int PWD_FIRST = 1;
  localparam int PWD_LAST = 16;
  localparam logic [7:0] CHS_MAX_SECTOR = 8'h3f;
  localparam logic [3:0] CHS_MAX_HEAD = 4'hf;
  localparam logic [7:0] STATUS_READY = 8'h40;
  typedef enum logic [2:0] {
    LS_UNLOCKED = 3'b001,
    LS_LOCKED = 3'b010,
    LS_FROZEN = 3'b100
  } sml_lock_type;
endpackage : sml_pkg

// *** sml_pwd_store.sv ***
`timescale 1ns/1ps
`default_nettype none
module sml_pwd_store
  import sml_pkg::*;
#(
  parameter int WORDS = 16
) (
  input wire logic clk, // Clock.
  input wire logic rst, // Asynchronous reset.
  input wire logic wr_en, // Store one password word.
  input wire logic [3:0] wr_idx, // Word index within password.
  input wire logic [15:0] wr_word, // Password word.
  input wire logic [3:0] rd_idx, // Read index.
  output logic [15:0] rd_word // Read word.
);
  logic [15:0] mem_r [WORDS];

  // Held only in flops, so a power cycle loses it.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < WORDS; i++) begin
        mem_r[i] <= 16'h0000;
      end
    end else if (wr_en) begin
      mem_r[wr_idx] <= wr_word;
    end
  end

  assign rd_word = mem_r[rd_idx];
endmodule : sml_pwd_store
`default_nettype wire

// *** sml_top.sv ***
// Chosen here: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Option bit picks persistent or volatile limit
// - Persistent request aborted in offset mode
// - CHS request uses cylinder registers only
// - LBA completion returns limit in registers
// - CHS completion returns sector 63, cylinder, head
// - Feature one without native read sets password
// - Password subcommand takes one data sector
// - Password is words one to sixteen
// - Password kept only until power cycle
// - Accepted password leaves device unlocked
// - Feature two without native read locks
// - Lock completion enters locked state
// - Locked rejects all but unlock, freeze
// - Locked until power cycle, unlock, freeze
// - After native read, treat as limit request
// - Busy, fault zero; abort reports error bits
// - Feature value chooses the subcommand
// - Limit request aborted when locked or frozen
module sml_top
  import sml_pkg::*;
#(
  parameter logic [27:0] NATIVE_MAX = 28'hfffffff
) (
  input wire logic clk, // Clock.
  input wire logic rst, // Asynchronous reset, active high.
  input wire logic hsel, // Slave select.
  input wire logic [31:0] haddr, // Address.
  input wire logic [1:0] htrans, // Transfer type.
  input wire logic hwrite, // Write.
  input wire logic [2:0] hsize, // Size.
  input wire logic [31:0] hwdata, // Write data.
  input wire logic hready, // Bus ready in.
  output logic [31:0] hrdata, // Read data.
  output logic hreadyout, // Slave ready.
  output logic hresp, // Response, always OKAY.
  output logic locked, // Limit locked state.
  output logic xfer_req // Data transfer requested.
);
  logic [7:0] feat_r;
  logic [7:0] seccnt_r;
  logic [7:0] secnum_r;
  logic [7:0] cyllo_r;
  logic [7:0] cylhi_r;
  logic [7:0] devhead_r;
  logic [7:0] err_r;
  logic [7:0] stat_r;
  logic offset_mode_r;
  logic native_read_r;
  logic nv_used_r;
  sml_lock_type lock_r;
  logic xfer_pend_r;
  logic hreadyout_r;
  logic hresp_r;
  logic [8:0] word_cnt_r;
  logic wr_ph_r;
  logic rd_ph_r;
  logic [7:0] addr_r;
  logic [3:0] pwd_rd_idx_r;
  logic [31:0] hrdata_r;
  logic locked_r;
  logic ld;
  logic [27:0] ld_val;
  logic [27:0] limit;
  logic persist;
  logic [15:0] pwd_word;

  function automatic logic [27:0] req_limit(input logic lba, input logic [7:0] sn,
      input logic [7:0] cl, input logic [7:0] ch, input logic [7:0] dh);
    if (lba) begin
      req_limit = {dh[3:0], ch, cl, sn};
    end else begin
      req_limit = {12'h000, ch, cl};
    end
  endfunction : req_limit

  wire acc = hsel && hready && htrans[1];
  wire wr_cmd = wr_ph_r && addr_r == OFF_CMD;
  wire wr_data = wr_ph_r && addr_r == OFF_DATA;
  wire is_limit_cmd = wr_cmd && hwdata[7:0] == CMD_SET_LIMIT;
  wire lba = devhead_r[BIT_LBA];
  wire want_nv = seccnt_r[BIT_PERSIST];
  wire limit_req = is_limit_cmd && native_read_r;
  wire sub_req = is_limit_cmd && !native_read_r;
  wire locked_now = lock_r != LS_UNLOCKED;
  wire limit_bad = locked_now || (want_nv && (offset_mode_r || nv_used_r));
  wire sub_known = feat_r >= FEAT_SET_PWD && feat_r <= FEAT_FREEZE;
  wire sub_bad = !sub_known || (lock_r == LS_LOCKED && feat_r != FEAT_UNLOCK
      && feat_r != FEAT_FREEZE) || (lock_r == LS_FROZEN);
  wire start_pwd = sub_req && !sub_bad && feat_r == FEAT_SET_PWD && !xfer_pend_r;
  wire last_word = wr_data && xfer_pend_r && word_cnt_r == 9'(SECTOR_WORDS - 1);
  wire pwd_en = wr_data && xfer_pend_r && word_cnt_r >= 9'(PWD_FIRST)
      && word_cnt_r <= 9'(PWD_LAST);

  assign ld = limit_req && !limit_bad;
  assign ld_val = req_limit(lba, secnum_r, cyllo_r, cylhi_r, devhead_r);

  sml_limit_store u_limit (
    .clk(clk),
    .rst(rst),
    .ld(ld),
    .ld_val(ld_val),
    .ld_persist(want_nv),
    .native_max(NATIVE_MAX),
    .limit(limit),
    .persist(persist)
  );

  sml_pwd_store #(.WORDS(PWD_LAST)) u_pwd (
    .clk(clk),
    .rst(rst),
    .wr_en(pwd_en),
    .wr_idx(4'(word_cnt_r - 9'(PWD_FIRST))),
    .wr_word(hwdata[15:0]),
    .rd_idx(pwd_rd_idx_r),
    .rd_word(pwd_word)
  );

  // Bus address phase capture; zero wait states.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ph_r <= 1'b0;
      rd_ph_r <= 1'b0;
      addr_r <= 8'h00;
    end else begin
      wr_ph_r <= acc && hwrite;
      rd_ph_r <= acc && !hwrite;
      if (acc) begin
        addr_r <= haddr[7:0];
      end
    end
  end

  // Command block writes; completion writes the returned limit back.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      feat_r <= 8'h00;
      seccnt_r <= 8'h00;
      secnum_r <= 8'h00;
      cyllo_r <= 8'h00;
      cylhi_r <= 8'h00;
      devhead_r <= 8'h00;
      offset_mode_r <= 1'b0;
      pwd_rd_idx_r <= 4'h0;
    end else if (limit_req && !limit_bad) begin
      if (lba) begin
        secnum_r <= ld_val[7:0];
        cyllo_r <= ld_val[15:8];
        cylhi_r <= ld_val[23:16];
        devhead_r <= {devhead_r[7:4], ld_val[27:24]};
      end else begin
        secnum_r <= CHS_MAX_SECTOR;
        devhead_r <= {devhead_r[7:4], CHS_MAX_HEAD};
      end
    end else if (wr_ph_r) begin
      unique case (addr_r)
        OFF_FEAT: feat_r <= hwdata[7:0];
        OFF_SECCNT: seccnt_r <= hwdata[7:0];
        OFF_SECNUM: secnum_r <= hwdata[7:0];
        OFF_CYLLO: cyllo_r <= hwdata[7:0];
        OFF_CYLHI: cylhi_r <= hwdata[7:0];
        OFF_DEVHEAD: devhead_r <= hwdata[7:0];
        OFF_CTRL: offset_mode_r <= hwdata[BIT_OFFSET_MODE];
        OFF_PWD: pwd_rd_idx_r <= hwdata[3:0];
        default: ;
      endcase
    end
  end

  // Native-maximum read arms only the very next command.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      native_read_r <= 1'b0;
    end else if (wr_cmd) begin
      native_read_r <= hwdata[7:0] == CMD_READ_NATIVE;
    end
  end

  // A second persistent request is refused until power cycle.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      nv_used_r <= 1'b0;
    end else if (ld && want_nv) begin
      nv_used_r <= 1'b1;
    end
  end

  // Lock state machine; unlock and freeze are only accepted here, not checked.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lock_r <= LS_UNLOCKED;
    end else if (last_word) begin
      lock_r <= LS_UNLOCKED;
    end else if (sub_req && !sub_bad) begin
      unique case (feat_r)
        FEAT_LOCK: lock_r <= LS_LOCKED;
        FEAT_UNLOCK: lock_r <= LS_UNLOCKED;
        FEAT_FREEZE: lock_r <= LS_FROZEN;
        default: ;
      endcase
    end
  end

  // One sector of data in for the password subcommand.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      xfer_pend_r <= 1'b0;
      word_cnt_r <= 9'h000;
    end else if (start_pwd) begin
      xfer_pend_r <= 1'b1;
      word_cnt_r <= 9'h000;
    end else if (wr_data && xfer_pend_r) begin
      word_cnt_r <= word_cnt_r + 9'h001;
      if (last_word) begin
        xfer_pend_r <= 1'b0;
      end
    end
  end

  // Completion status; busy and fault stay zero.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      err_r <= 8'h00;
      stat_r <= STATUS_READY;
    end else if (is_limit_cmd) begin
      if ((limit_req && limit_bad) || (sub_req && sub_bad)) begin
        err_r <= 8'h01 << BIT_ABORT;
        stat_r <= STATUS_READY | (8'h01 << BIT_ERR);
      end else begin
        err_r <= 8'h00;
        stat_r <= start_pwd ? (STATUS_READY | (8'h01 << BIT_XFER_REQ)) : STATUS_READY;
      end
    end else if (last_word) begin
      err_r <= 8'h00;
      stat_r <= STATUS_READY;
    end
  end

  // Read data register.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hrdata_r <= 32'h00000000;
    end else if (acc && !hwrite) begin
      unique case (haddr[7:0])
        OFF_FEAT: hrdata_r <= {24'h000000, feat_r};
        OFF_SECCNT: hrdata_r <= {24'h000000, seccnt_r};
        OFF_SECNUM: hrdata_r <= {24'h000000, secnum_r};
        OFF_CYLLO: hrdata_r <= {24'h000000, cyllo_r};
        OFF_CYLHI: hrdata_r <= {24'h000000, cylhi_r};
        OFF_DEVHEAD: hrdata_r <= {24'h000000, devhead_r};
        OFF_ERROR: hrdata_r <= {24'h000000, err_r};
        OFF_STATUS: hrdata_r <= {24'h000000, stat_r};
        OFF_LIMIT: hrdata_r <= {3'h0, persist, limit};
        OFF_CTRL: hrdata_r <= {31'h00000000, offset_mode_r};
        OFF_STATE: hrdata_r <= {28'h0000000, nv_used_r, native_read_r, lock_r == LS_FROZEN, locked_now};
        OFF_PWD: hrdata_r <= {16'h0000, pwd_word};
        default: hrdata_r <= 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      locked_r <= 1'b0;
    end else begin
      locked_r <= locked_now;
    end
  end

  // Failures are reported in the status register, never as a bus error, so the slave never stalls or errors.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hreadyout_r <= 1'b1;
      hresp_r <= 1'b0;
    end else begin
      hreadyout_r <= 1'b1;
      hresp_r <= 1'b0;
    end
  end

  assign hrdata = hrdata_r;
  assign hreadyout = hreadyout_r;
  assign hresp = hresp_r;
  assign locked = locked_r;
  assign xfer_req = xfer_pend_r;
endmodule : sml_top
`default_nettype wire

// *** sml_top_props.sv ***
`timescale 1ns/1ps
`default_nettype none
module sml_props
  import sml_pkg::*;
#(
  parameter logic [27:0] NATIVE_MAX = 28'hfffffff
) (
  input wire logic clk, // Clock.
  input wire logic rst, // Reset.
  input wire logic hsel, // Select.
  input wire logic [31:0] haddr, // Address.
  input wire logic [1:0] htrans, // Transfer type.
  input wire logic hwrite, // Write.
  input wire logic [2:0] hsize, // Size.
  input wire logic [31:0] hwdata, // Write data.
  input wire logic hready, // Bus ready.
  input wire logic [31:0] hrdata, // Read data.
  input wire logic hreadyout, // Slave ready.
  input wire logic hresp, // Response.
  input wire logic locked, // Lock state.
  input wire logic xfer_req // Transfer pending.
);
  logic ap_v;
  logic ap_w;
  logic [7:0] ap_a;
  logic [7:0] feat_r;
  logic [8:0] dcnt_r;
  wire logic rd_ok = ap_v && !ap_w;
  wire logic wr_ok = ap_v && ap_w;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ap_v <= 1'b0;
      ap_w <= 1'b0;
      ap_a <= 8'h00;
    end else begin
      ap_v <= hsel && hready && htrans[1];
      ap_w <= hwrite;
      ap_a <= haddr[7:0];
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      feat_r <= 8'h00;
    else if (wr_ok && ap_a == OFF_FEAT)
      feat_r <= hwdata[7:0];
  end
  // Counts only while a transfer is pending, so stray data writes do not count.
  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      dcnt_r <= 9'h000;
    else if (wr_ok && ap_a == OFF_CMD)
      dcnt_r <= 9'h000;
    else if (wr_ok && ap_a == OFF_DATA && xfer_req)
      dcnt_r <= dcnt_r + 9'h001;
  end
  a_status_clean: assert property (
    rd_ok && ap_a == OFF_STATUS |-> !hrdata[BIT_BUSY] && !hrdata[BIT_FAULT])
    else $error("status shows busy or fault");
  a_error_bits: assert property (
    rd_ok && ap_a == OFF_ERROR |-> (hrdata & 32'hfffffffb) == 32'h0)
    else $error("error register has a bit beside abort");
  a_lock_cause: assert property (
    $rose(locked) |-> feat_r == FEAT_LOCK || feat_r == FEAT_FREEZE)
    else $error("lock entered without lock code");
  a_unlock_cause: assert property (
    $fell(locked) |-> feat_r == FEAT_UNLOCK)
    else $error("lock left without unlock code");
  a_locked_holds: assert property (
    locked && feat_r != FEAT_UNLOCK |=> locked)
    else $error("lock dropped");
  a_pwd_feature: assert property (
    $rose(xfer_req) |-> feat_r == FEAT_SET_PWD)
    else $error("transfer without password code");
  a_pwd_open: assert property (
    $rose(xfer_req) |-> !locked)
    else $error("password taken while locked");
  a_one_sector: assert property (
    $fell(xfer_req) |-> dcnt_r == 9'h100)
    else $error("sector length wrong");
  a_pwd_unlocks: assert property (
    $fell(xfer_req) |-> !locked)
    else $error("locked after password");
  a_bus_okay: assert property (
    hresp == 1'b0 && hreadyout == 1'b1)
    else $error("bus response not okay");
endmodule : sml_props
bind sml_top sml_props #(.NATIVE_MAX(NATIVE_MAX)) props_u (.clk(clk), .rst(rst), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
  .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .locked(locked), .xfer_req(xfer_req));
`default_nettype wire

// *** testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
module testbench
  import sml_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic hsel, hwrite, hready, hresp, locked, xfer_req, done;
  logic [31:0] haddr, hwdata, hrdata, val, m_r, d;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [27:0] lim, plim;
  logic [15:0] pw[16];
  logic [31:0] exp_q[$];
  logic [31:0] msk_q[$];
  int n_errors = 0;
  int num_checks = 0;
  int cyc = 0;
  always #2 clk = ~clk;
  sml_top dut_u (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hready),
    .hresp(hresp), .locked(locked), .xfer_req(xfer_req));
  sml_host host_u (.clk(clk), .ready(hready), .rdata(hrdata), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .done(done), .val(val));
  task automatic cmp_word(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask : cmp_word
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    host_u.xfer(1'b1, a, {24'h0, v});
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = 32'hffffffff);
    exp_q.push_back(e);
    msk_q.push_back(m);
    host_u.xfer(1'b0, a, 32'h0);
  endtask : rd
  // Status bits 4 and 1 are left open, so they are masked out.
  task automatic st(input logic [7:0] s, input logic [7:0] e);
    rd(OFF_STATUS, {24'h0, s}, 32'hed);
    rd(OFF_ERROR, {24'h0, e});
  endtask : st
  task automatic cmd(input logic [7:0] f, sc, input logic [27:0] v, input logic l, nat);
    if (nat)
      wr(OFF_CMD, CMD_READ_NATIVE);
    wr(OFF_FEAT, f);
    wr(OFF_SECCNT, sc);
    wr(OFF_SECNUM, v[7:0]);
    wr(OFF_CYLLO, v[15:8]);
    wr(OFF_CYLHI, v[23:16]);
    wr(OFF_DEVHEAD, {1'b1, l, 2'b10, v[27:24]});
    wr(OFF_CMD, CMD_SET_LIMIT);
  endtask : cmd
  always @(posedge clk)
    if (done) begin
      m_r = msk_q.pop_front();
      cmp_word(val & m_r, exp_q.pop_front() & m_r);
    end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      give_verdict();
    end
  end
  initial begin
    void'($urandom(32'h9b66587e));
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    st(8'h40, 8'h00);
    rd(8'h3c, 32'h0);
    $display("reset test done");
    for (int i = 0; i < 4; i++) begin
      lim = 28'($urandom());
      cmd(8'($urandom()), 8'h00, lim, i[0], 1'b1);
      st(8'h40, 8'h00);
      rd(OFF_SECNUM, i[0] ? {24'h0, lim[7:0]} : 32'h3f, 32'hff);
      rd(OFF_CYLLO, {24'h0, lim[15:8]}, 32'hff);
      rd(OFF_CYLHI, {24'h0, lim[23:16]}, 32'hff);
      rd(OFF_DEVHEAD, i[0] ? {28'h0, lim[27:24]} : 32'hf, 32'hf);
      rd(OFF_LIMIT, i[0] ? {4'h0, lim} : {16'h0, lim[23:8]}, 32'h1fffffff);
    end
    $display("limit test done");
    plim = 28'($urandom());
    wr(OFF_CTRL, 8'h01);
    cmd(8'h00, 8'h01, plim, 1'b1, 1'b1);
    st(8'h41, 8'h04);
    wr(OFF_CTRL, 8'h00);
    cmd(8'h00, 8'h01, plim, 1'b1, 1'b1);
    st(8'h40, 8'h00);
    rd(OFF_LIMIT, {4'h1, plim}, 32'h1fffffff);
    foreach (pw[i]) begin
      cmd(8'(5 + i * 16), 8'h00, 28'h0, 1'b1, 1'b0);
      st(8'h41, 8'h04);
    end
    $display("option test done");
    cmd(FEAT_SET_PWD, 8'h00, 28'h0, 1'b1, 1'b0);
    st(8'h48, 8'h00);
    for (int i = 0; i < 256; i++) begin
      d = $urandom();
      if (i >= 1 && i <= 16)
        pw[i - 1] = d[15:0];
      host_u.xfer(1'b1, OFF_DATA, d);
    end
    st(8'h40, 8'h00);
    foreach (pw[i]) begin
      wr(OFF_PWD, 8'(i));
      rd(OFF_PWD, {16'h0, pw[i]}, 32'hffff);
    end
    cmp_word({31'h0, locked}, 32'h0);
    $display("password test done");
    cmd(FEAT_LOCK, 8'h00, 28'h0, 1'b1, 1'b0);
    st(8'h40, 8'h00);
    cmp_word({31'h0, locked}, 32'h1);
    cmd(8'h00, 8'h00, 28'h5, 1'b1, 1'b1);
    st(8'h41, 8'h04);
    cmd(FEAT_SET_PWD, 8'h00, 28'h0, 1'b1, 1'b0);
    st(8'h41, 8'h04);
    cmd(FEAT_UNLOCK, 8'h00, 28'h0, 1'b1, 1'b0);
    st(8'h40, 8'h00);
    cmp_word({31'h0, locked}, 32'h0);
    cmd(FEAT_FREEZE, 8'h00, 28'h0, 1'b1, 1'b0);
    st(8'h40, 8'h00);
    cmp_word({31'h0, locked}, 32'h1);
    cmd(FEAT_UNLOCK, 8'h00, 28'h0, 1'b1, 1'b0);
    st(8'h41, 8'h04);
    rd(OFF_STATE, 32'hb);
    $display("lock test done");
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    cmp_word({31'h0, locked}, 32'h0);
    wr(OFF_PWD, 8'h00);
    rd(OFF_PWD, 32'h0, 32'hffff);
    rd(OFF_LIMIT, {4'h1, plim}, 32'h1fffffff);
    rd(OFF_STATE, 32'h0);
    $display("power cycle test done");
    while (exp_q.size() != 0)
      @(posedge clk);
    give_verdict();
  end
endmodule : testbench
`default_nettype wire
